// [rtl/rsync_pkg.sv]
package rsync_pkg;
	// register byte offsets
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] SET_OFS = 8'h08;
	localparam logic [7:0] SYNC_OFS = 8'h0c;
	localparam logic [7:0] CTRL_OFS = 8'h10;
	// command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_HI_LSB = 8;
	localparam int CMD_LO_LSB = 16;
	// control fields
	localparam int CTRL_EN_A = 0;
	localparam int CTRL_EN_B = 1;
	localparam int CTRL_EN_ACT = 2;
	localparam int CTRL_PREDEF = 3;
	// reset and factory values and parameter limits
	localparam logic [3:0] CTRL_DEF = 4'hf;
	localparam logic [4:0] RANGE_DEF = 5'h1f;
	localparam logic [7:0] RANGE_MAX = 8'h1f;
	localparam logic [7:0] ATT_MIN = 8'h09;
	localparam logic [7:0] ATT_MAX = 8'h0f;
	localparam logic [2:0] ATT_DEF_DB = 3'h0;
	localparam logic [7:0] SYNC_DEF = 8'h00;
	localparam logic [7:0] HOLD_DEF = 8'h00;
	localparam logic [7:0] HOLD_MAX = 8'h0a;
	localparam logic [3:0] PULSE_DEF = 4'hc;
	// time base
	localparam int MS_NS = 1000000;
	localparam int CLK_NS = 10;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam logic [9:0] PULSE_MS [16] = '{10'd4, 10'd8, 10'd12, 10'd16, 10'd20, 10'd24,
		10'd32, 10'd40, 10'd48, 10'd60, 10'd76, 10'd152, 10'd228, 10'd300, 10'd376, 10'd752};
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [7:0] {
		OP_RANGE_A = 8'h01,
		OP_TX_ATT = 8'h02,
		OP_RANGE_B = 8'h03,
		OP_ACT_ATT = 8'h04,
		OP_SYNC_DELAY = 8'h05,
		OP_SYNC_HOLD = 8'h06,
		OP_CLR_PFAIL = 8'h07,
		OP_LOAD_DEF = 8'h08,
		OP_PULSE_LEN = 8'h09,
		OP_RESET_RDR = 8'h0a
	} cmd_op_t;
	typedef enum logic [3:0] {
		ST_OFF = 4'b0001,
		ST_COUNT = 4'b0010,
		ST_HOLD = 4'b0100,
		ST_RUN = 4'b1000
	} sync_st_t;
endpackage

// [rtl/ms_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ms_tick_if;
	logic tick;
	modport src (output tick);
	modport snk (input tick);
endinterface
`default_nettype wire

// [rtl/ms_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module ms_tick import rsync_pkg::*; #(
	parameter int unsigned CYCLES = MS_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	ms_tick_if.src tk
);
	logic [31:0] cnt_q;

	// one-cycle tick every millisecond
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q <= 32'h0;
			tk.tick <= 1'b0;
		end else if (cnt_q == 32'(CYCLES - 1)) begin
			cnt_q <= 32'h0;
			tk.tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tk.tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [rtl/pulse_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module pulse_timer import rsync_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	ms_tick_if.snk tk,
	input wire logic i_restart,
	input wire logic i_clear,
	input wire logic [3:0] i_code,
	output logic o_active
);
	logic [9:0] cnt_q;

	assign o_active = (cnt_q != 10'h0);

	always_ff @(posedge i_clk) begin
		if (i_rst || i_clear) begin
			cnt_q <= 10'h0;
		end else if (i_restart) begin
			cnt_q <= PULSE_MS[i_code];
		end else if (tk.tick && cnt_q != 10'h0) begin
			cnt_q <= cnt_q - 10'h1;
		end
	end
endmodule
`default_nettype wire

// [rtl/reader_sync_output_control.sv]
`timescale 1ns/1ps
`default_nettype none
module reader_sync_output_control import rsync_pkg::*; #(
	parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [7:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic I_SYNC_RX,
	input wire logic I_TAG_ACQ,
	input wire logic I_PROTO_DONE,
	output logic O_SYNC_TX,
	output logic [2:0] O_RUN_PROTO,
	output logic O_GATE_OUT_FIRST,
	output logic O_GATE_OUT_SECOND,
	output logic O_READER_RESET,
	output logic O_POWER_FAIL,
	output logic [4:0] O_RANGE_A,
	output logic [4:0] O_RANGE_B,
	output logic [2:0] O_TX_ATTEN_DB,
	output logic [2:0] O_ACTIVE_ATTEN_DB
);
	function automatic logic [4:0] hexval(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
		if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
			return {1'b1, c[3:0] + 4'h9};
		return 5'h00;
	endfunction

	function automatic logic [31:0] lanes(input logic [31:0] d, input logic [3:0] s);
		return d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus slave
	logic aw_got_q, w_got_q, wr_go, rr_go, cmd_go;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	assign wr_go = aw_got_q && w_got_q && !O_BVALID;
	assign cmd_go = wr_go && awaddr_q == CMD_OFS;

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			aw_got_q <= 1'b0;
			O_AWREADY <= 1'b1;
			awaddr_q <= 8'h0;
		end else if (I_AWVALID && O_AWREADY) begin
			aw_got_q <= 1'b1;
			O_AWREADY <= 1'b0;
			awaddr_q <= I_AWADDR;
		end else if (O_BVALID && I_BREADY) begin
			aw_got_q <= 1'b0;
			O_AWREADY <= 1'b1;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			w_got_q <= 1'b0;
			O_WREADY <= 1'b1;
			wdata_q <= 32'h0;
		end else if (I_WVALID && O_WREADY) begin
			w_got_q <= 1'b1;
			O_WREADY <= 1'b0;
			wdata_q <= lanes(I_WDATA, I_WSTRB);
		end else if (O_BVALID && I_BREADY) begin
			w_got_q <= 1'b0;
			O_WREADY <= 1'b1;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			O_BVALID <= 1'b0;
			O_BRESP <= RESP_OKAY;
		end else if (wr_go) begin
			O_BVALID <= 1'b1;
			O_BRESP <= (awaddr_q == CMD_OFS || awaddr_q == CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
		end else if (I_BREADY) begin
			O_BVALID <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command decode
	logic [4:0] hx_hi, hx_lo;
	logic [7:0] val;
	logic ok;
	logic [3:0] ctrl_q, pulse_q;
	logic [4:0] range_a_q, range_b_q;
	logic [2:0] tx_db_q, act_db_q;
	logic [7:0] delay_q, hold_q, cmd_cnt_q;
	logic [31:0] last_cmd_q;
	logic resp_err_q, pfail_q;
	assign hx_hi = hexval(wdata_q[CMD_HI_LSB +: 8]);
	assign hx_lo = hexval(wdata_q[CMD_LO_LSB +: 8]);
	assign val = {hx_hi[3:0], hx_lo[3:0]};

	always_comb begin
		case (wdata_q[CMD_OP_LSB +: 8])
			OP_RANGE_A, OP_RANGE_B: ok = hx_hi[4] && hx_lo[4] && val <= RANGE_MAX;
			OP_TX_ATT, OP_ACT_ATT: ok = hx_hi[4] && hx_lo[4] && val >= ATT_MIN && val <= ATT_MAX;
			OP_SYNC_DELAY: ok = hx_hi[4] && hx_lo[4];
			OP_SYNC_HOLD: ok = hx_hi[4] && hx_lo[4] && val <= HOLD_MAX;
			OP_PULSE_LEN: ok = hx_lo[4];
			OP_CLR_PFAIL, OP_LOAD_DEF, OP_RESET_RDR: ok = 1'b1;
			default: ok = 1'b0;
		endcase
	end

	logic ld_def, sync_wr;
	assign ld_def = cmd_go && ok && wdata_q[7:0] == OP_LOAD_DEF;
	assign sync_wr = ld_def || (cmd_go && ok && (wdata_q[7:0] == OP_SYNC_DELAY));
	assign rr_go = cmd_go && ok && wdata_q[7:0] == OP_RESET_RDR;

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST || ld_def) begin
			range_a_q <= RANGE_DEF;
			range_b_q <= RANGE_DEF;
		end else if (cmd_go && ok) begin
			if (wdata_q[7:0] == OP_RANGE_A) range_a_q <= val[4:0];
			if (wdata_q[7:0] == OP_RANGE_B) range_b_q <= val[4:0];
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST || ld_def) begin
			tx_db_q <= ATT_DEF_DB;
			act_db_q <= ATT_DEF_DB;
		end else if (cmd_go && ok) begin
			if (wdata_q[7:0] == OP_TX_ATT) tx_db_q <= 3'(val - ATT_MIN);
			if (wdata_q[7:0] == OP_ACT_ATT) act_db_q <= 3'(val - ATT_MIN);
		end
	end

	// sync, hold-off, pulse and control defaults
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST || ld_def) begin
			delay_q <= SYNC_DEF;
			hold_q <= HOLD_DEF;
			pulse_q <= PULSE_DEF;
			ctrl_q <= CTRL_DEF;
		end else begin
			if (cmd_go && ok && wdata_q[7:0] == OP_SYNC_DELAY) delay_q <= val;
			if (cmd_go && ok && wdata_q[7:0] == OP_SYNC_HOLD) hold_q <= val;
			if (cmd_go && ok && wdata_q[7:0] == OP_PULSE_LEN) pulse_q <= hx_lo[3:0];
			if (wr_go && awaddr_q == CTRL_OFS) ctrl_q <= wdata_q[3:0];
		end
	end

	// power-fail flag, set by power-up reset
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			pfail_q <= 1'b1;
		end else if (cmd_go && ok && (wdata_q[7:0] == OP_CLR_PFAIL || rr_go)) begin
			pfail_q <= 1'b0;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			resp_err_q <= 1'b0;
			cmd_cnt_q <= 8'h0;
			last_cmd_q <= 32'h0;
			O_READER_RESET <= 1'b0;
		end else begin
			O_READER_RESET <= rr_go;
			if (cmd_go) begin
				resp_err_q <= !ok;
				cmd_cnt_q <= cmd_cnt_q + 8'h1;
				last_cmd_q <= wdata_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sync bus
	ms_tick_if tk ();
	ms_tick #(.CYCLES(MS_CYCLES_P)) u_tick (.i_clk(I_CLOCK), .i_rst(I_SYS_RST), .tk(tk.src));

	logic rx_m_q, rx_s_q, rx_d_q, peer_edge, own_fire, sync_ev, hold_use;
	logic [7:0] cnt_q;
	sync_st_t st_q;
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			rx_m_q <= 1'b0;
			rx_s_q <= 1'b0;
			rx_d_q <= 1'b0;
		end else begin
			rx_m_q <= I_SYNC_RX;
			rx_s_q <= rx_m_q;
			rx_d_q <= rx_s_q;
		end
	end
	assign peer_edge = rx_s_q && !rx_d_q;
	assign own_fire = st_q == ST_COUNT && tk.tick && cnt_q == 8'h01;
	assign sync_ev = st_q == ST_COUNT && !sync_wr && (own_fire || peer_edge);
	assign hold_use = ctrl_q[CTRL_EN_ACT] && hold_q != 8'h00 && delay_q != 8'h00;

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			st_q <= ST_OFF;
			cnt_q <= 8'h0;
			O_SYNC_TX <= 1'b0;
			O_RUN_PROTO <= 3'b000;
		end else begin
			O_SYNC_TX <= 1'b0;
			O_RUN_PROTO <= 3'b000;
			if (sync_wr) begin
				st_q <= (ld_def || val == 8'h00) ? ST_OFF : ST_COUNT;
				cnt_q <= ld_def ? SYNC_DEF : val;
			end else begin
				case (st_q)
					ST_OFF: st_q <= ST_OFF;
					ST_COUNT: begin
						if (sync_ev) begin
							O_SYNC_TX <= own_fire;
							O_RUN_PROTO[1:0] <= {ctrl_q[CTRL_EN_B], ctrl_q[CTRL_EN_A]};
							O_RUN_PROTO[2] <= ctrl_q[CTRL_EN_ACT] && !hold_use;
							st_q <= hold_use ? ST_HOLD : ST_RUN;
							cnt_q <= hold_q;
						end else if (tk.tick) begin
							cnt_q <= cnt_q - 8'h1;
						end
					end
					ST_HOLD: begin
						if (tk.tick && cnt_q == 8'h01) begin
							O_RUN_PROTO[2] <= 1'b1;
							st_q <= ST_RUN;
						end else if (tk.tick) begin
							cnt_q <= cnt_q - 8'h1;
						end
					end
					ST_RUN: begin
						if (I_PROTO_DONE) begin
							st_q <= ST_COUNT;
							cnt_q <= delay_q;
						end
					end
					default: st_q <= ST_OFF;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output pulse
	logic pt_active;
	pulse_timer u_pulse (.i_clk(I_CLOCK), .i_rst(I_SYS_RST), .tk(tk.snk),
		.i_restart(I_TAG_ACQ && ctrl_q[CTRL_PREDEF]), .i_clear(rr_go),
		.i_code(pulse_q), .o_active(pt_active));

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST || rr_go) begin
			O_GATE_OUT_FIRST <= 1'b0;
			O_GATE_OUT_SECOND <= 1'b0;
		end else begin
			O_GATE_OUT_FIRST <= pt_active && ctrl_q[CTRL_PREDEF];
			O_GATE_OUT_SECOND <= pt_active && ctrl_q[CTRL_PREDEF];
		end
	end

	assign O_POWER_FAIL = pfail_q;
	assign O_RANGE_A = range_a_q;
	assign O_RANGE_B = range_b_q;
	assign O_TX_ATTEN_DB = tx_db_q;
	assign O_ACTIVE_ATTEN_DB = act_db_q;

	////////////////////////////////////////////////////////////////////////
	// read path
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			O_ARREADY <= 1'b1;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0;
			O_RRESP <= RESP_OKAY;
		end else if (I_ARVALID && O_ARREADY) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b1;
			O_RRESP <= RESP_OKAY;
			case (I_ARADDR)
				CMD_OFS: O_RDATA <= last_cmd_q;
				STAT_OFS: O_RDATA <= {8'h0, cmd_cnt_q, 2'b0, st_q, 2'b0,
					O_GATE_OUT_SECOND, O_GATE_OUT_FIRST, pulse_q, pfail_q, resp_err_q};
				SET_OFS: O_RDATA <= {4'h0, 4'(act_db_q + 3'h1) + 4'h8, 4'h0,
					4'(tx_db_q + 3'h1) + 4'h8, 3'h0, range_b_q, 3'h0, range_a_q};
				// delay and hold-off in one word
				SYNC_OFS: O_RDATA <= {16'h0, hold_q, delay_q};
				CTRL_OFS: O_RDATA <= {28'h0, ctrl_q};
				default: begin
					O_RDATA <= 32'h0;
					O_RRESP <= RESP_SLVERR;
				end
			endcase
		end else if (O_RVALID && I_RREADY) begin
			O_RVALID <= 1'b0;
			O_ARREADY <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_SYS_RST);

	range_default_a: assert property ($fell(I_SYS_RST) |-> range_a_q == RANGE_DEF && range_b_q == RANGE_DEF)
		else $error("range not at default after reset");
	att_map_a: assert property (cmd_go && ok && wdata_q[7:0] == OP_TX_ATT |=> tx_db_q == 3'($past(val) - 8'h09))
		else $error("attenuation map wrong");
	bad_keep_a: assert property (cmd_go && !ok |=> $stable(range_a_q) && $stable(delay_q) && resp_err_q)
		else $error("bad parameter changed a setting");
	sync_off_a: assert property (delay_q == 8'h00 [*3] |-> !O_SYNC_TX && O_RUN_PROTO == 3'b000)
		else $error("sync activity while disabled");
	peer_run_a: assert property (peer_edge && sync_ev |=> O_RUN_PROTO[0] == ctrl_q[CTRL_EN_A] && !O_SYNC_TX ##1 st_q != ST_COUNT)
		else $error("peer pulse did not start protocols");
	no_hold_a: assert property (sync_ev && ctrl_q[CTRL_EN_ACT] && hold_q == 8'h00 |=> O_RUN_PROTO[2])
		else $error("active run delayed without hold-off");
	hold_wait_a: assert property (st_q == ST_HOLD && !tk.tick |=> !O_RUN_PROTO[2])
		else $error("active run during hold-off");
	pfail_clr_a: assert property (cmd_go && ok && wdata_q[7:0] == OP_CLR_PFAIL |=> !O_POWER_FAIL)
		else $error("power-fail not cleared");
	gate_on_a: assert property (I_TAG_ACQ && ctrl_q[CTRL_PREDEF] ##1 !rr_go && ctrl_q[CTRL_PREDEF] |=> O_GATE_OUT_FIRST && O_GATE_OUT_SECOND)
		else $error("gates not asserted on tag");
	rr_clear_a: assert property (rr_go |=> !O_GATE_OUT_FIRST && !O_POWER_FAIL && O_READER_RESET)
		else $error("reader reset incomplete");

	own_pulse_c: cover property (own_fire ##1 O_SYNC_TX);
	peer_pulse_c: cover property (peer_edge && st_q == ST_COUNT);
	hold_run_c: cover property (st_q == ST_HOLD ##[1:1000] O_RUN_PROTO[2]);
	tag_retrig_c: cover property (I_TAG_ACQ ##[1:100] I_TAG_ACQ);
endmodule
`default_nettype wire

// [tb/peer_model.sv]
`timescale 1ns/1ps
`default_nettype none
module peer_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [2:0] i_run,
	input wire logic [2:0] i_en,
	input wire logic i_fire,
	input wire logic i_slow,
	output logic o_sync,
	output logic o_done
);
	logic [2:0] seen_q;
	int cnt_q;
	int wid_q;
	////////////////////////////////////////////////////////////////
	// pulse from a peer with another delay
	always_ff @(posedge i_clk) begin
		if (i_rst) wid_q <= 0;
		else if (i_fire) wid_q <= 3;
		else if (wid_q > 0) wid_q <= wid_q - 1;
	end
	assign o_sync = (wid_q > 0);
	////////////////////////////////////////////////////////////////
	// done only after every enabled protocol ran
	always_ff @(posedge i_clk) begin
		o_done <= 1'b0;
		if (i_rst) begin
			seen_q <= 3'h0;
			cnt_q <= 0;
		end else if (cnt_q == 1) begin
			o_done <= 1'b1;
			cnt_q <= 0;
			seen_q <= 3'h0;
		end else if (cnt_q > 1) cnt_q <= cnt_q - 1;
		else if ((seen_q | i_run) != 3'h0 && ((seen_q | i_run) & i_en) == i_en) cnt_q <= i_slow ? 20 : 1;
		else seen_q <= seen_q | i_run;
	end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top import rsync_pkg::*;;
	localparam int MSC = 10;
	logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic tag = 1'b0, fire = 1'b0, slow = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rnd = 32'h7;
	logic [3:0] wstrb = 4'hf;
	logic [2:0] en = 3'h7;
	logic awready, wready, bvalid, arready, rvalid, sync_rx, done, sync_tx, g1, g2, rrst, pf;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] run, att_tx, att_act;
	logic [4:0] ra, rb;
	int mismatches = 0, samples_checked = 0, cyc = 0, tx_t = 0, rr_n = 0;
	int run_t[3] = '{0, 0, 0};
	int e_ra = 31, e_rb = 31, e_tx = 9, e_act = 9, e_dly = 0, e_hold = 0, e_code = 12, e_pf = 1;
	int e_err = 0;
	int pms[16] = '{4, 8, 12, 16, 20, 24, 32, 40, 48, 60, 76, 152, 228, 300, 376, 752};
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (sync_tx) tx_t <= cyc;
		if (rrst) rr_n <= rr_n + 1;
		for (int k = 0; k < 3; k++) if (run[k]) run_t[k] <= cyc;
	end
	reader_sync_output_control #(.MS_CYCLES_P(MSC)) reader_sync_output_control_inst (
		.I_CLOCK(clk), .I_SYS_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(awready),
		.I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wv), .O_WREADY(wready), .O_BRESP(bresp),
		.O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv),
		.O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
		.I_RREADY(rready), .I_SYNC_RX(sync_rx), .I_TAG_ACQ(tag), .I_PROTO_DONE(done),
		.O_SYNC_TX(sync_tx), .O_RUN_PROTO(run), .O_GATE_OUT_FIRST(g1), .O_GATE_OUT_SECOND(g2),
		.O_READER_RESET(rrst), .O_POWER_FAIL(pf), .O_RANGE_A(ra), .O_RANGE_B(rb),
		.O_TX_ATTEN_DB(att_tx), .O_ACTIVE_ATTEN_DB(att_act));
	peer_model peer_model_inst (.i_clk(clk), .i_rst(rst), .i_run(run), .i_en(en), .i_fire(fire),
		.i_slow(slow), .o_sync(sync_rx), .o_done(done));
	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic hang(input int n, input int lim);
		if (n >= lim) begin
			mismatches++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (awv && awready) awv <= 1'b0;
			if (wv && wready) wv <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		hang(n, 100);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (arv && arready) arv <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		hang(n, 100);
	endtask
	function automatic int dg(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) return c - 48;
		if (c >= 8'h61 && c <= 8'h66) return c - 87;
		if (c >= 8'h41 && c <= 8'h46) return c - 55;
		return -1;
	endfunction
	function automatic logic [7:0] hx(input int v, input bit up);
		if (v < 10) return 8'(48 + v);
		return 8'((up ? 55 : 87) + v);
	endfunction
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic compare;
		logic [31:0] d;
		logic [1:0] r;
		chk("range_a", ra, e_ra);
		chk("range_b", rb, e_rb);
		chk("tx_db", att_tx, e_tx - 9);
		chk("act_db", att_act, e_act - 9);
		chk("power_fail", pf, e_pf);
		rd(SET_OFS, d, r);
		chk("set_reg", d, (e_act << 24) | (e_tx << 16) | (e_rb << 8) | e_ra);
		rd(SYNC_OFS, d, r);
		chk("sync_reg", d, (e_hold << 8) | e_dly);
		rd(STAT_OFS, d, r);
		chk("cmd_err", d[0], e_err);
		chk("pulse_code", d[5:2], e_code);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] hi, input logic [7:0] lo);
		logic [1:0] r;
		int v;
		v = (dg(hi) < 0 || dg(lo) < 0) ? -1 : dg(hi) * 16 + dg(lo);
		e_err = 0;
		case (op)
			8'h01: if (v >= 0 && v <= 31) e_ra = v; else e_err = 1;
			8'h02: if (v >= 9 && v <= 15) e_tx = v; else e_err = 1;
			8'h03: if (v >= 0 && v <= 31) e_rb = v; else e_err = 1;
			8'h04: if (v >= 9 && v <= 15) e_act = v; else e_err = 1;
			8'h05: if (v >= 0) e_dly = v; else e_err = 1;
			8'h06: if (v >= 0 && v <= 10) e_hold = v; else e_err = 1;
			8'h07, 8'h0a: e_pf = 0;
			8'h08: {e_ra, e_rb, e_tx, e_act, e_dly, e_hold, e_code} = {32'd31, 32'd31, 32'd9, 32'd9, 96'd12};
			8'h09: if (dg(lo) >= 0) e_code = dg(lo); else e_err = 1;
			default: e_err = 1;
		endcase
		wr(CMD_OFS, {8'h00, lo, hi, op}, r);
		repeat (2) @(posedge clk);
		compare();
	endtask
	task automatic tagw(output int w);
		int n;
		@(posedge clk);
		tag <= 1'b1;
		@(posedge clk);
		tag <= 1'b0;
		for (n = 0; n < 5 && !g1; n++) @(posedge clk);
		chk("gate_pair", {g1, g2}, 2'b11);
		for (w = 0; w < 9000 && g1; w++) @(posedge clk);
		hang(w, 9000);
	endtask
	task automatic wtx(output int w);
		for (w = 0; w < 4000; w++) begin
			@(posedge clk);
			if (sync_tx) break;
		end
		hang(w, 4000);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		int i, w, t;
		logic [31:0] d;
		logic [1:0] r;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		compare();
		rd(CTRL_OFS, d, r);
		chk("ctrl", d, 32'hf);
		$display("test reset values over");
		for (i = 9; i < 16; i++) begin
			cmd(8'h02, "0", hx(i, i[0]));
			cmd(8'h04, "0", hx(i, !i[0]));
		end
		for (i = 0; i < 24; i++) begin
			rnd = xs(rnd);
			cmd(8'(1 + i % 6), hx(rnd[5:4], rnd[8]), hx(rnd[3:0], rnd[9]));
		end
		cmd(8'h01, "g", "1");
		cmd(8'h33, "0", "0");
		wr(STAT_OFS, 32'h0, r);
		chk("ro_write", r, RESP_SLVERR);
		rd(8'h40, d, r);
		chk("unmapped", d, 32'h0);
		chk("unmapped_resp", r, RESP_SLVERR);
		cmd(8'h07, "0", "0");
		$display("test commands over");
		for (i = 0; i < 16; i++) begin
			cmd(8'h09, "0", hx(i, i[1]));
			tagw(w);
			chk("pulse_len", w >= (pms[i] - 1) * MSC && w <= pms[i] * MSC + 4, 1);
		end
		tagw(w);
		@(posedge clk);
		tag <= 1'b1;
		@(posedge clk);
		tag <= 1'b0;
		cmd(8'h0a, "0", "0");
		chk("gate_reset", {g1, g2}, 2'b00);
		chk("reader_reset", rr_n, 1);
		cmd(8'h09, "0", "0");
		@(posedge clk);
		tag <= 1'b1;
		@(posedge clk);
		tag <= 1'b0;
		repeat (20) @(posedge clk);
		tagw(w);
		chk("retrigger", w >= 3 * MSC && w <= 4 * MSC + 6, 1);
		$display("test pulses over");
		cmd(8'h06, "0", "0");
		cmd(8'h05, "0", "3");
		wtx(w);
		wtx(w);
		chk("delay_len", w >= 2 * MSC && w <= 3 * MSC + 8, 1);
		repeat (2) @(posedge clk);
		chk("run_all", run_t[2] == tx_t && run_t[0] == tx_t, 1);
		cmd(8'h06, "0", "3");
		wtx(w);
		repeat (40) @(posedge clk);
		chk("holdoff", run_t[2] - tx_t >= 2 * MSC && run_t[2] - tx_t <= 3 * MSC + 4, 1);
		chk("run_first", run_t[0] == tx_t, 1);
		wr(CTRL_OFS, 32'h3, r);
		en <= 3'h3;
		wtx(w);
		repeat (40) @(posedge clk);
		chk("no_holdoff", run_t[2] < tx_t && run_t[1] == tx_t, 1);
		wr(CTRL_OFS, 32'hf, r);
		en <= 3'h7;
		slow <= 1'b1;
		cmd(8'h06, "0", "0");
		cmd(8'h05, "F", "f");
		wtx(w);
		repeat (1000) @(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		t = cyc;
		repeat (10) @(posedge clk);
		chk("peer_run", run_t[0] > t && run_t[2] > t && tx_t < t, 1);
		wtx(w);
		chk("restart", cyc - t >= 254 * MSC && cyc - t <= 255 * MSC + 40, 1);
		cmd(8'h05, "0", "0");
		t = cyc;
		repeat (100) @(posedge clk);
		chk("sync_off", run_t[0] < t && tx_t < t, 1);
		$display("test sync over");
		cmd(8'h01, "0", "5");
		cmd(8'h06, "0", "A");
		cmd(8'h08, "0", "0");
		$display("test defaults over");
		end_of_test();
	end
endmodule
`default_nettype wire
